// >>> nv_access_monitor.sv
// Checker for the byte access block, bound to its top module.
// Assumes one core clock and the block's own bus, arm and stall timing.
`timescale 1ns/1ns
`default_nettype none
module nv_access_monitor #(
    parameter int NV_BYTES        = 2048,
    parameter int WRITE_RC_CYCLES = 27072
) (
    // Clock and resets
    input wire logic                    core_clk_i,
    input wire logic                    sys_rst_i,
    input wire logic                    por_rst_i,
    // Bus and status
    input wire nv_access_pkg::io_req_t io_req_i,
    input wire logic [7:0]              io_rdata_o,
    input wire logic                    cpu_stall_o,
    input wire logic                    global_irq_flag_i,
    input wire logic                    flash_selfprog_busy_i,
    input wire logic                    ready_irq_o,
    input wire logic                    rc_osc_i
);
    import nv_access_pkg::*;
    // ********
    // Shadow of the arm window
    // ********
    logic [2:0] arm_cnt_reg;
    wire        ctrl_wr = io_req_i.we && io_req_i.addr == OFS_CONTROL;
    wire        free    = ready_irq_o && !flash_selfprog_busy_i && !cpu_stall_o;
    wire        wstrobe = ctrl_wr && io_req_i.wdata[CTRL_WRITE_BIT];
    wire        launch  = wstrobe && arm_cnt_reg != 3'h0 && free;
    wire        rstrobe = ctrl_wr && io_req_i.wdata[1:0] == 2'b01 && free;
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            arm_cnt_reg <= 3'h0;
        end else if (ctrl_wr && io_req_i.wdata[CTRL_ARM_BIT]) begin
            arm_cnt_reg <= ARM_CYCLES;
        end else if (arm_cnt_reg != 3'h0) begin
            arm_cnt_reg <= arm_cnt_reg - 3'h1;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    rsv_ctrl_a: assert property (
        io_req_i.re && io_req_i.addr == OFS_CONTROL |=>
        (io_rdata_o & 8'hF1) == 8'h00) else $error("ctrl reserved bits");
    rsv_high_a: assert property (
        io_req_i.re && io_req_i.addr == OFS_ADDR_HIGH |=>
        io_rdata_o[7:3] == 5'h00) else $error("addr high reserved bits");
    read_stall_a: assert property (
        rstrobe |=> cpu_stall_o [*4] ##1 !cpu_stall_o)
        else $error("read stall length");
    launch_stall_a: assert property (
        launch |=> cpu_stall_o [*2] ##1 !cpu_stall_o)
        else $error("write stall length");
    launch_busy_a: assert property (
        launch |=> !ready_irq_o [*8]) else $error("ready during write");
    no_arm_a: assert property (
        wstrobe && arm_cnt_reg == 3'h0 && free
        && io_req_i.wdata[CTRL_IRQEN_BIT] && !io_req_i.wdata[CTRL_READ_BIT]
        |=> !cpu_stall_o && ready_irq_o)
        else $error("unarmed strobe started");
    flash_hold_a: assert property (
        wstrobe && flash_selfprog_busy_i && !cpu_stall_o
        && !io_req_i.wdata[CTRL_READ_BIT] |=> !cpu_stall_o)
        else $error("write during flash");
    stall_max_a: assert property (
        cpu_stall_o [*4] |=> !cpu_stall_o) else $error("stall too long");
    irq_gate_a: assert property (
        !global_irq_flag_i |-> !ready_irq_o) else $error("irq not gated");
    cover property (launch);
    cover property (rstrobe);
    cover property (wstrobe && flash_selfprog_busy_i);
endmodule : nv_access_monitor
bind nv_byte_access_ctrl nv_access_monitor #(
    .NV_BYTES       (NV_BYTES),
    .WRITE_RC_CYCLES(WRITE_RC_CYCLES)
) nv_access_monitor_inst (
    .core_clk_i           (core_clk_i),
    .sys_rst_i            (sys_rst_i),
    .por_rst_i            (por_rst_i),
    .io_req_i             (io_req_i),
    .io_rdata_o           (io_rdata_o),
    .cpu_stall_o          (cpu_stall_o),
    .global_irq_flag_i    (global_irq_flag_i),
    .flash_selfprog_busy_i(flash_selfprog_busy_i),
    .ready_irq_o          (ready_irq_o),
    .rc_osc_i             (rc_osc_i)
);
`default_nettype wire

// >>> nv_access_pkg.sv
// Shared constants and types for the byte-wide nonvolatile access block.
// Assumes a CPU I/O bus with 6-bit register addresses and 8-bit data.
`default_nettype none

package nv_access_pkg;

    // ********************************************************
    // Register map (I/O addresses)
    // ********************************************************
    localparam logic [5:0] OFS_CONTROL   = 6'h1F;
    localparam logic [5:0] OFS_DATA      = 6'h20;
    localparam logic [5:0] OFS_ADDR_LOW  = 6'h21;
    localparam logic [5:0] OFS_ADDR_HIGH = 6'h22;

    // ********************************************************
    // Field layout
    // ********************************************************
    localparam int CTRL_READ_BIT  = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_ARM_BIT   = 2;
    localparam int CTRL_IRQEN_BIT = 3;
    localparam int ADDR_W         = 11;
    localparam int ADDR_HIGH_W    = 3;
    localparam int DATA_W         = 8;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam logic [2:0] ARM_CYCLES    = 3'h4;
    localparam logic [2:0] READ_STALL    = 3'h4;
    localparam logic [2:0] WRITE_STALL   = 3'h2;
    localparam int         WRITE_RC_DEF  = 27072;
    localparam int         NV_BYTES_DEF  = 2048;

    // ********************************************************
    // Types
    // ********************************************************
    typedef struct packed {
        logic        we;
        logic        re;
        logic [5:0]  addr;
        logic [7:0]  wdata;
    } io_req_t;

endpackage : nv_access_pkg

`default_nettype wire

// >>> nv_byte_access_ctrl.sv
// Byte read and write control for the on-chip data EEPROM array.
// Assumes a CPU I/O bus request each cycle, a stall input on the core,
// and an RC oscillator pin that keeps running during a write.
`default_nettype none
`timescale 1ns/1ns

module nv_byte_access_ctrl #(
    parameter int NV_BYTES        = nv_access_pkg::NV_BYTES_DEF,
    parameter int WRITE_RC_CYCLES = nv_access_pkg::WRITE_RC_DEF
) (
    // Clock and resets
    input  wire logic                  core_clk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  por_rst_i,
    // CPU I/O register bus
    input  wire nv_access_pkg::io_req_t io_req_i,
    output logic [7:0]                 io_rdata_o,
    // CPU side status
    output logic                       cpu_stall_o,
    input  wire logic                  global_irq_flag_i,
    input  wire logic                  flash_selfprog_busy_i,
    output logic                       ready_irq_o,
    // Calibrated RC oscillator
    input  wire logic                  rc_osc_i
);
    import nv_access_pkg::*;

    localparam int IDX_W = $clog2(NV_BYTES);

    // ********************************************************
    // State
    // ********************************************************
    logic [ADDR_W-1:0] nv_byte_index_reg;
    logic [DATA_W-1:0] nv_byte_buffer_reg;
    logic              ready_irq_enable_reg;
    logic [2:0]        arm_cnt_reg;
    logic [2:0]        stall_cnt_reg;
    logic [IDX_W-1:0]  prog_addr_reg;
    logic [DATA_W-1:0] prog_data_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] nv_array [0:NV_BYTES-1];

    // ********************************************************
    // Decoding
    // ********************************************************
    wire rc_tick;
    wire write_busy;
    wire write_done;

    wire wr_low   = io_req_i.we && (io_req_i.addr == OFS_ADDR_LOW);
    wire wr_high  = io_req_i.we && (io_req_i.addr == OFS_ADDR_HIGH);
    wire wr_data  = io_req_i.we && (io_req_i.addr == OFS_DATA);
    wire wr_ctrl  = io_req_i.we && (io_req_i.addr == OFS_CONTROL);

    wire write_arm_enable = (arm_cnt_reg != 3'h0);
    wire write_strobe     = write_busy;

    wire [IDX_W-1:0] byte_idx = nv_byte_index_reg[IDX_W-1:0];

    // Strobe honoured only while armed, idle and flash is quiet
    wire launch   = wr_ctrl && io_req_i.wdata[CTRL_WRITE_BIT]
                    && write_arm_enable
                    && !write_busy
                    && !flash_selfprog_busy_i;
    wire read_go  = wr_ctrl && io_req_i.wdata[CTRL_READ_BIT]
                    && !write_busy && !launch;
    wire arm_set  = wr_ctrl && io_req_i.wdata[CTRL_ARM_BIT];

    wire [7:0] ctrl_view = {4'h0, ready_irq_enable_reg,
                            write_arm_enable, write_strobe, 1'b0};
    wire [7:0] high_view = {{(8-ADDR_HIGH_W){1'b0}},
                            nv_byte_index_reg[ADDR_W-1:8]};
    wire [7:0] read_mux  =
        (io_req_i.addr == OFS_ADDR_LOW)  ? nv_byte_index_reg[7:0] :
        (io_req_i.addr == OFS_ADDR_HIGH) ? high_view :
        (io_req_i.addr == OFS_DATA)      ? nv_byte_buffer_reg :
        (io_req_i.addr == OFS_CONTROL)   ? ctrl_view : 8'h00;

    // ********************************************************
    // Submodules
    // ********************************************************
    rc_tick_sync u_sync (
        .core_clk_i (core_clk_i),
        .por_rst_i  (por_rst_i),
        .rc_osc_i   (rc_osc_i),
        .rc_tick_o  (rc_tick)
    );

    nv_write_timer #(
        .RC_CYCLES (WRITE_RC_CYCLES)
    ) u_timer (
        .core_clk_i (core_clk_i),
        .por_rst_i  (por_rst_i),
        .start_i    (launch),
        .rc_tick_i  (rc_tick),
        .busy_o     (write_busy),
        .done_o     (write_done)
    );

    // ********************************************************
    // Address and data registers
    // ********************************************************
    // No reset: contents are undefined until software loads them
    always_ff @(posedge core_clk_i) begin
        if (wr_low && !write_busy) begin
            nv_byte_index_reg[7:0] <= io_req_i.wdata;
        end
        if (wr_high && !write_busy) begin
            nv_byte_index_reg[ADDR_W-1:8] <=
                io_req_i.wdata[ADDR_HIGH_W-1:0];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (read_go) begin
            nv_byte_buffer_reg <= nv_array[byte_idx];
        end else if (wr_data) begin
            nv_byte_buffer_reg <= io_req_i.wdata;
        end
    end

    // ********************************************************
    // Programming path
    // ********************************************************
    // Latched at launch so later data writes cannot corrupt the byte
    always_ff @(posedge core_clk_i) begin
        if (launch) begin
            prog_addr_reg <= byte_idx;
            prog_data_reg <= nv_byte_buffer_reg;
        end
        if (write_done) begin
            nv_array[prog_addr_reg] <= prog_data_reg;
        end
    end

    // ********************************************************
    // Control register bits
    // ********************************************************
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ready_irq_enable_reg <= 1'b0;
        end else if (wr_ctrl) begin
            ready_irq_enable_reg <= io_req_i.wdata[CTRL_IRQEN_BIT];
        end
    end

    // A new set in the timeout cycle wins and restarts the window
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            arm_cnt_reg <= 3'h0;
        end else if (arm_set) begin
            arm_cnt_reg <= ARM_CYCLES;
        end else if (write_arm_enable) begin
            arm_cnt_reg <= arm_cnt_reg - 3'h1;
        end
    end

    // ********************************************************
    // CPU stall
    // ********************************************************
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stall_cnt_reg <= 3'h0;
        end else if (read_go) begin
            stall_cnt_reg <= READ_STALL;
        end else if (launch) begin
            stall_cnt_reg <= WRITE_STALL;
        end else if (stall_cnt_reg != 3'h0) begin
            stall_cnt_reg <= stall_cnt_reg - 3'h1;
        end
    end

    assign cpu_stall_o = (stall_cnt_reg != 3'h0);

    // ********************************************************
    // Bus read data and interrupt
    // ********************************************************
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 8'h00;
        end else if (io_req_i.re) begin
            rdata_reg <= read_mux;
        end
    end

    assign io_rdata_o  = rdata_reg;
    assign ready_irq_o = ready_irq_enable_reg & global_irq_flag_i
                         & ~write_strobe;

endmodule : nv_byte_access_ctrl

`default_nettype wire

// >>> nv_write_timer.sv
// Times one programming cycle in RC oscillator ticks.
// Assumes start only arrives while idle.
`default_nettype none
`timescale 1ns/1ns

module nv_write_timer #(
    parameter int RC_CYCLES = 27072
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic por_rst_i,
    // Control
    input  wire logic start_i,
    input  wire logic rc_tick_i,
    // Status
    output logic      busy_o,
    output logic      done_o
);
    localparam int CNT_W = $clog2(RC_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(RC_CYCLES - 1);

    logic [CNT_W-1:0] count_reg;
    logic             busy_reg;

    assign done_o = busy_reg & rc_tick_i & (count_reg == LAST);
    assign busy_o = busy_reg;

    // Only power-on reset touches this, so a write survives sys reset
    always_ff @(posedge core_clk_i or posedge por_rst_i) begin
        if (por_rst_i) begin
            busy_reg  <= 1'b0;
            count_reg <= '0;
        end else if (start_i) begin
            busy_reg  <= 1'b1;
            count_reg <= '0;
        end else if (done_o) begin
            busy_reg  <= 1'b0;
        end else if (busy_reg && rc_tick_i) begin
            count_reg <= count_reg + 1'b1;
        end
    end

endmodule : nv_write_timer

`default_nettype wire

// >>> rc_osc_model.sv
// Calibrated RC oscillator seen by the block.
// Assumes nothing; it runs free, unrelated in phase to the core clock.
`timescale 1ns/1ns
`default_nettype none
module rc_osc_model #(
    parameter int HALF_NS = 230
) (
    // Oscillator pin
    output logic rc_osc_o
);
    initial rc_osc_o = 1'b0;
    always #(HALF_NS) rc_osc_o = ~rc_osc_o;
endmodule : rc_osc_model
`default_nettype wire

// >>> rc_tick_sync.sv
// Brings the calibrated RC oscillator into the core clock domain.
// Assumes the RC oscillator runs well below half the core clock.
`default_nettype none
`timescale 1ns/1ns

module rc_tick_sync (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic por_rst_i,
    // Oscillator pin
    input  wire logic rc_osc_i,
    // One-cycle pulse per oscillator rising edge
    output logic      rc_tick_o
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    always_ff @(posedge core_clk_i or posedge por_rst_i) begin
        if (por_rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= rc_osc_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign rc_tick_o = sync_reg & ~prev_reg;

endmodule : rc_tick_sync

`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the byte access block.
// Assumes the bound checker and a free running oscillator model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import nv_access_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        por_rst_i = 1'b1;
    io_req_t     req = '0;
    logic        gie = 1'b1;
    logic        fbusy = 1'b0;
    logic [7:0]  io_rdata_o;
    logic        cpu_stall_o;
    logic        ready_irq_o;
    logic        rc_osc;
    logic [7:0]  rv;
    logic [10:0] a;
    logic [10:0] b;
    logic [31:0] lfsr = 32'h21AF;
    logic [7:0]  mem [0:2047];
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    always #25 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    nv_byte_access_ctrl #(
        .NV_BYTES       (2048),
        .WRITE_RC_CYCLES(8)
    ) nv_byte_access_ctrl_inst (
        .core_clk_i           (core_clk_i),
        .sys_rst_i            (sys_rst_i),
        .por_rst_i            (por_rst_i),
        .io_req_i             (req),
        .io_rdata_o           (io_rdata_o),
        .cpu_stall_o          (cpu_stall_o),
        .global_irq_flag_i    (gie),
        .flash_selfprog_busy_i(fbusy),
        .ready_irq_o          (ready_irq_o),
        .rc_osc_i             (rc_osc)
    );
    rc_osc_model rc_osc_model_inst (.rc_osc_o(rc_osc));
    // ********
    // Bus tasks and expectations
    // ********
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    function automatic logic [7:0] hi_exp(input logic [10:0] x);
        return {5'h00, x[10:8]};
    endfunction : hi_exp
    task automatic check(input string w, input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, s);
        end
    endtask : check
    // Leaves the write request up so the next write follows back to back
    task automatic wr(input logic [5:0] ad, input logic [7:0] d);
        @(negedge core_clk_i);
        req = '{1'b1, 1'b0, ad, d};
    endtask : wr
    task automatic rd(input logic [5:0] ad, output logic [7:0] d);
        @(negedge core_clk_i);
        req = '{1'b0, 1'b1, ad, 8'h00};
        @(negedge core_clk_i);
        req.re = 1'b0;
        @(negedge core_clk_i);
        d = io_rdata_o;
    endtask : rd
    task automatic wait_idle();
        for (int i = 0; i < 200; i++) begin
            rd(OFS_CONTROL, rv);
            if (rv[CTRL_WRITE_BIT] === 1'b0) return;
        end
        fail_count++;
    endtask : wait_idle
    task automatic nv_write(input logic [10:0] x, input logic [7:0] d);
        wr(OFS_ADDR_HIGH, hi_exp(x));
        wr(OFS_ADDR_LOW, x[7:0]);
        wr(OFS_DATA, d);
        wr(OFS_CONTROL, 8'h0C);
        wr(OFS_CONTROL, 8'h0E);
        mem[x] = d;
    endtask : nv_write
    task automatic nv_check(input logic [10:0] x);
        wr(OFS_ADDR_HIGH, hi_exp(x));
        wr(OFS_ADDR_LOW, x[7:0]);
        wr(OFS_CONTROL, 8'h09);
        @(negedge core_clk_i);
        req.we = 1'b0;
        check("read stall", {7'h00, cpu_stall_o}, 8'h01);
        rd(OFS_DATA, rv);
        check("array byte", rv, mem[x]);
        check("stall held", {7'h00, cpu_stall_o}, 8'h01);
        @(negedge core_clk_i);
        check("stall end", {7'h00, cpu_stall_o}, 8'h00);
    endtask : nv_check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // ********
    // Scenarios
    // ********
    initial begin
        repeat (20) @(posedge core_clk_i);
        @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        por_rst_i = 1'b0;
        rd(OFS_CONTROL, rv);
        check("ctrl after reset", rv, 8'h00);
        wr(OFS_ADDR_HIGH, 8'hFF);
        rd(OFS_ADDR_HIGH, rv);
        check("addr high", rv, 8'h07);
        for (int n = 0; n < 8; n++) begin
            lfsr = lfsr_next(lfsr);
            a = (n == 0) ? 11'h7FF : (n == 1) ? 11'h000 : lfsr[10:0];
            nv_write(a, lfsr[23:16]);
            @(negedge core_clk_i);
            req.we = 1'b0;
            check("write stall", {7'h00, cpu_stall_o}, 8'h01);
            rd(OFS_CONTROL, rv);
            check("busy", rv & 8'hFB, 8'h0A);
            check("irq busy", {7'h00, ready_irq_o}, 8'h00);
            wait_idle();
            check("irq ready", {7'h00, ready_irq_o}, 8'h01);
            nv_check(a);
        end
        wr(OFS_DATA, ~mem[a]);
        wr(OFS_CONTROL, 8'h0A);
        rd(OFS_CONTROL, rv);
        check("unarmed", rv, 8'h08);
        wr(OFS_CONTROL, 8'h0C);
        rd(OFS_CONTROL, rv);
        check("armed", rv, 8'h0C);
        repeat (3) @(negedge core_clk_i);
        rd(OFS_CONTROL, rv);
        check("arm timeout", rv, 8'h08);
        wr(OFS_CONTROL, 8'h0A);
        rd(OFS_CONTROL, rv);
        check("late strobe", rv, 8'h08);
        nv_check(a);
        b = a ^ 11'h155;
        nv_write(b, lfsr[31:24]);
        wr(OFS_ADDR_LOW, ~b[7:0]);
        wr(OFS_CONTROL, 8'h09);
        rd(OFS_DATA, rv);
        check("read while busy", rv, mem[b]);
        rd(OFS_ADDR_LOW, rv);
        check("addr while busy", rv, b[7:0]);
        wait_idle();
        nv_check(b);
        fbusy = 1'b1;
        nv_write(b, ~mem[b]);
        mem[b] = ~mem[b];
        rd(OFS_CONTROL, rv);
        check("flash block", rv & 8'h02, 8'h00);
        fbusy = 1'b0;
        nv_check(b);
        nv_write(a, lfsr[15:8]);
        rd(OFS_CONTROL, rv);
        check("busy at reset", rv & 8'h02, 8'h02);
        sys_rst_i = 1'b1;
        @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        wait_idle();
        nv_check(a);
        gie = 1'b0;
        #1;
        check("irq masked", {7'h00, ready_irq_o}, 8'h00);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
